// [rtl/plds_pkg.sv]
/*
  Shared constants and carrier types for the link criteria and speed downshift block.
  Assumes a 125 MHz system clock and a plain one-cycle register port.
*/
package plds_pkg;

  // Register indices (16-bit management registers, word addressed)
  localparam logic [4:0] REG_CTRL   = 5'h00;
  localparam logic [4:0] REG_ADV    = 5'h04;
  localparam logic [4:0] REG_LP     = 5'h05;
  localparam logic [4:0] REG_PCFG   = 5'h10;
  localparam logic [4:0] REG_PSTAT  = 5'h11;
  localparam logic [4:0] REG_EVT    = 5'h13;
  localparam logic [4:0] REG_DSCFG  = 5'h1b;

  // Field positions
  localparam int CTRL_PWRDN_BIT   = 11;
  localparam int ADV_PAUSE_BIT    = 10;
  localparam int ADV_ASYM_BIT     = 11;
  localparam int LP_PAUSE_LSB     = 10;
  localparam int PCFG_DSHIFT_BIT  = 7;
  localparam int PCFG_LTDIS_BIT   = 14;
  localparam int PSTAT_SPEED_LSB  = 14;
  localparam int EVT_DSHIFT_BIT   = 5;
  localparam int DSCFG_CNT_LSB    = 6;

  // Reset values
  localparam logic [15:0] CTRL_RST  = 16'h1000;
  localparam logic [15:0] ADV_RST   = 16'h0000;
  localparam logic [15:0] PCFG_RST  = 16'h0000;
  localparam logic [15:0] DSCFG_RST = 16'h0080;

  // Timing
  localparam int CLK_KHZ          = 125000;
  localparam int NLP_TX_MS        = 16;
  localparam int NLP_RX_MIN_MS    = 10;
  localparam int NLP_RX_MAX_MS    = 20;
  localparam int RESTORE_MS       = 2000;
  localparam int NLP_TX_CYC       = NLP_TX_MS * CLK_KHZ;
  localparam int NLP_RX_MIN_CYC   = NLP_RX_MIN_MS * CLK_KHZ;
  localparam int NLP_RX_MAX_CYC   = NLP_RX_MAX_MS * CLK_KHZ;
  localparam int RESTORE_CYC      = RESTORE_MS * CLK_KHZ;
  localparam int NLP_GOOD_NEED    = 2;

  // Speed codes
  typedef enum logic [1:0] {
    SPD_10   = 2'b00,
    SPD_100  = 2'b01,
    SPD_1000 = 2'b10
  } plds_speed_t;

  // Line-side receive indications from the analog/DSP path
  typedef struct packed {
    logic train_done_local;
    logic train_done_remote;
    logic gig_sym_valid;
    logic desc_lock;
    logic idle_rate_ok;
    logic normal_link_pulse;
    logic an_done;
    logic gig_fail;
  } plds_line_t;

  // Register port request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } plds_req_t;

endpackage : plds_pkg

// [rtl/plds_link_ctrl.sv]
/*
  Link-up/keep criteria, speed downshift and restore, pause advertisement exchange
  and software power-down for a copper PHY.
  Assumes line indications arrive asynchronously and are synchronised here; register
  port comes from logic on clk. Partner pause bits are captured at negotiation end.
*/
// Design decisions made here: strobed register access and the register addresses.
// Functional notes
// - Gigabit link first trains filters on exchanged idle symbols.
// - Gigabit link comes up only when both ends signal training complete.
// - Gigabit link holds while valid symbols arrive; idles fill gaps when sending.
// - Fast link sends idles at once, up when descrambler locks and stays locked.
// - Fast link holds unless received idle rate falls below minimum.
// - Ten-meg mode sends one normal link pulse every 16 ms.
// - Partner pulses every 10 to 20 ms keep a ten-meg link up.
// - Without downshift a failed gigabit attempt retries same speeds forever.
// - With downshift, after 1-5 failures lower advertised top speed one step.
// - Downshifted link established then lost over two seconds restores advertisement.
// - Bit 7 of register 16 enables downshift.
// - A downshift sets status bit 5 of register 19.
// - Resolved speed shows in register 17 bits 15:14 while link is up.
// - Local pause bits in register 4; partner pause bits in register 5 bits 11:10.
// - 16-bit management registers exposed over the management port.
// - In low-power mode nothing is transmitted or received.
// - Register 0 bit 11 powers down the port; registers remain accessible.
// - Clearing power-down re-initialises analog but keeps configuration.
// - With link test on, transmit enables after 2 pulses, disables when they stop.
`timescale 1ns/10ps
module plds_link_ctrl #(
  parameter int NLP_TX_CYC  = plds_pkg::NLP_TX_CYC,
  parameter int NLP_MAX_CYC = plds_pkg::NLP_RX_MAX_CYC,
  parameter int RESTORE_CYC = plds_pkg::RESTORE_CYC
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                arst_n,
  // Register port
  input  wire plds_pkg::plds_req_t req,
  output logic [15:0]              rdata,
  // Line side indications (asynchronous)
  input  wire plds_pkg::plds_line_t line_in,
  input  wire logic [1:0]          lp_pause_in,
  input  wire logic [1:0]          neg_speed_in,
  // Line side controls
  output logic                     send_idle,
  output logic                     nlp_tx,
  output logic                     tx_enable,
  output logic                     rx_enable,
  output logic                     analog_reinit,
  output logic [1:0]               adv_top_speed,
  // Status and MAC power control
  input  wire logic                mac_pwrdn,
  output logic                     link_up
);

  localparam int CW = 32;

  // Two-stage synchronisers for every line-side level
  logic [7:0] line_s1_reg;
  logic [7:0] line_s2_reg;
  logic [3:0] aux_s1_reg;
  logic [3:0] aux_s2_reg;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      line_s1_reg <= 8'h00;
      line_s2_reg <= 8'h00;
      aux_s1_reg  <= 4'h0;
      aux_s2_reg  <= 4'h0;
    end
    else
    begin
      line_s1_reg <= line_in;
      line_s2_reg <= line_s1_reg;
      aux_s1_reg  <= {lp_pause_in, neg_speed_in};
      aux_s2_reg  <= aux_s1_reg;
    end
  end

  plds_pkg::plds_line_t ln;
  assign ln = line_s2_reg;

  // Registers and state
  logic [15:0] ctrl_reg, ctrl_next;
  logic [15:0] adv_reg, adv_next;
  logic [1:0]  lp_reg, lp_next;
  logic [15:0] pcfg_reg, pcfg_next;
  logic [15:0] dscfg_reg, dscfg_next;
  logic        dsev_reg, dsev_next;
  logic [1:0]  top_reg, top_next;
  logic [1:0]  spd_reg, spd_next;
  logic [2:0]  fail_reg, fail_next;
  logic        shifted_reg, shifted_next;
  logic        up_reg, up_next;
  logic [CW-1:0] nlp_tx_cnt_reg, nlp_tx_cnt_next;
  logic [CW-1:0] nlp_rx_cnt_reg, nlp_rx_cnt_next;
  logic [CW-1:0] lost_cnt_reg, lost_cnt_next;
  logic [2:0]  nlp_seen_reg, nlp_seen_next;
  logic        nlp_prev_reg, nlp_prev_next;
  logic        nlp_tx_reg, nlp_tx_next;
  logic        txen_reg, txen_next;
  logic        rxen_reg, rxen_next;
  logic        idle_reg, idle_next;
  logic        pwr_prev_reg, pwr_prev_next;
  logic        reinit_reg, reinit_next;
  logic        fail_prev_reg, fail_prev_next;
  logic        an_prev_reg, an_prev_next;
  logic [15:0] rdata_reg, rdata_next;

  logic        pwrdn;
  logic        ds_en;
  logic [2:0]  ds_limit;
  logic        link_ok;
  logic        nlp_edge;
  logic        fail_edge;
  logic        dsev_set;

  assign pwrdn     = ctrl_reg[plds_pkg::CTRL_PWRDN_BIT] | mac_pwrdn;
  assign ds_en     = pcfg_reg[plds_pkg::PCFG_DSHIFT_BIT];
  assign ds_limit  = dscfg_reg[plds_pkg::DSCFG_CNT_LSB +: 3];
  assign nlp_edge  = ln.normal_link_pulse & ~nlp_prev_reg;
  assign fail_edge = ln.gig_fail & ~fail_prev_reg;

  // Link criteria per resolved speed
  always_comb
  begin
    link_ok = 1'b0;
    unique case (spd_reg)
      plds_pkg::SPD_1000:
        // Training on idles, then both ends flip idle coding; keep on valid symbols
        link_ok = ln.train_done_local & ln.train_done_remote & ln.gig_sym_valid;
      plds_pkg::SPD_100:
        link_ok = ln.desc_lock & ln.idle_rate_ok;
      plds_pkg::SPD_10:
        link_ok = (nlp_seen_reg >= 3'(plds_pkg::NLP_GOOD_NEED))
                  && (nlp_rx_cnt_reg < CW'(NLP_MAX_CYC));
      default:
        link_ok = 1'b0;
    endcase
    if (pwrdn)
      link_ok = 1'b0;
  end

  // Next-state logic for link, downshift, pulses and registers
  always_comb
  begin
    ctrl_next       = ctrl_reg;
    adv_next        = adv_reg;
    lp_next         = lp_reg;
    pcfg_next       = pcfg_reg;
    dscfg_next      = dscfg_reg;
    dsev_next       = dsev_reg;
    top_next        = top_reg;
    spd_next        = spd_reg;
    fail_next       = fail_reg;
    shifted_next    = shifted_reg;
    up_next         = link_ok;
    nlp_tx_cnt_next = nlp_tx_cnt_reg;
    nlp_rx_cnt_next = nlp_rx_cnt_reg;
    lost_cnt_next   = lost_cnt_reg;
    nlp_seen_next   = nlp_seen_reg;
    nlp_prev_next   = ln.normal_link_pulse;
    fail_prev_next  = ln.gig_fail;
    an_prev_next    = ln.an_done;
    nlp_tx_next     = 1'b0;
    pwr_prev_next   = ctrl_reg[plds_pkg::CTRL_PWRDN_BIT];
    reinit_next     = pwr_prev_reg & ~ctrl_reg[plds_pkg::CTRL_PWRDN_BIT];
    rdata_next      = 16'h0000;
    dsev_set        = 1'b0;

    // Negotiated speed and partner pause captured when negotiation completes
    if (ln.an_done & ~an_prev_reg)
    begin
      spd_next = (aux_s2_reg[1:0] > top_reg) ? top_reg : aux_s2_reg[1:0];
      lp_next  = aux_s2_reg[3:2];
    end

    // Normal link pulse transmit timer, 10 Mb/s only
    if (spd_reg == plds_pkg::SPD_10 && !pwrdn)
    begin
      if (nlp_tx_cnt_reg >= CW'(NLP_TX_CYC - 1))
      begin
        nlp_tx_cnt_next = '0;
        nlp_tx_next     = 1'b1;
      end
      else
        nlp_tx_cnt_next = nlp_tx_cnt_reg + 1'b1;
    end
    else
      nlp_tx_cnt_next = '0;

    // Receive pulse watchdog; a gap past the window drops the count
    if (nlp_edge)
    begin
      nlp_rx_cnt_next = '0;
      if (nlp_seen_reg != 3'h7)
        nlp_seen_next = nlp_seen_reg + 1'b1;
    end
    else if (nlp_rx_cnt_reg < CW'(NLP_MAX_CYC))
      nlp_rx_cnt_next = nlp_rx_cnt_reg + 1'b1;
    else
      nlp_seen_next = 3'h0;

    // Failed gigabit attempts and downshift
    if (link_ok)
      fail_next = 3'h0;
    else if (fail_edge && top_reg == plds_pkg::SPD_1000 || fail_edge && shifted_reg)
    begin
      if (!ds_en)
        fail_next = 3'h0;
      else if (top_reg != plds_pkg::SPD_10 && fail_reg + 3'h1 >= ds_limit)
      begin
        top_next     = top_reg - 2'b01;
        shifted_next = 1'b1;
        fail_next    = 3'h0;
        dsev_next    = 1'b1;
        dsev_set     = 1'b1;
      end
      else
        fail_next = fail_reg + 3'h1;
    end

    // Restore original advertisement after a long loss of a downshifted link
    if (link_ok)
      lost_cnt_next = '0;
    else if (shifted_reg && up_reg)
      lost_cnt_next = 32'h1;
    else if (shifted_reg && lost_cnt_reg != '0)
    begin
      if (lost_cnt_reg > CW'(RESTORE_CYC))
      begin
        top_next      = plds_pkg::SPD_1000;
        shifted_next  = 1'b0;
        lost_cnt_next = '0;
      end
      else
        lost_cnt_next = lost_cnt_reg + 1'b1;
    end

    // Register writes
    if (req.wr)
    begin
      unique case (req.addr)
        plds_pkg::REG_CTRL:  ctrl_next  = req.wdata;
        plds_pkg::REG_ADV:   adv_next   = req.wdata;
        plds_pkg::REG_PCFG:  pcfg_next  = req.wdata;
        plds_pkg::REG_DSCFG: dscfg_next = req.wdata;
        default:             ;
      endcase
    end

    // Register reads, one cycle latency; status bit clears on read, set wins
    if (req.rd)
    begin
      unique case (req.addr)
        plds_pkg::REG_CTRL:  rdata_next = ctrl_reg;
        plds_pkg::REG_ADV:   rdata_next = adv_reg;
        plds_pkg::REG_LP:    rdata_next = 16'(lp_reg) << plds_pkg::LP_PAUSE_LSB;
        plds_pkg::REG_PCFG:  rdata_next = pcfg_reg;
        plds_pkg::REG_PSTAT: rdata_next = up_reg ? 16'(spd_reg) << plds_pkg::PSTAT_SPEED_LSB
                                                 : 16'h0000;
        plds_pkg::REG_EVT:
        begin
          rdata_next = 16'(dsev_reg) << plds_pkg::EVT_DSHIFT_BIT;
          if (!dsev_set)
            dsev_next = 1'b0;
        end
        plds_pkg::REG_DSCFG: rdata_next = dscfg_reg;
        default:             rdata_next = 16'h0000;
      endcase
    end
  end

  // Transmit/receive gating; link test may be disabled by software
  always_comb
  begin
    idle_next = ~pwrdn & (spd_reg != plds_pkg::SPD_10);
    rxen_next = ~pwrdn & link_ok;
    if (spd_reg == plds_pkg::SPD_10 && !pcfg_reg[plds_pkg::PCFG_LTDIS_BIT])
      txen_next = ~pwrdn & (nlp_seen_reg >= 3'(plds_pkg::NLP_GOOD_NEED));
    else
      txen_next = ~pwrdn & link_ok;
  end

  // State registers; power-down leaves configuration untouched
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl_reg       <= plds_pkg::CTRL_RST;
      adv_reg        <= plds_pkg::ADV_RST;
      lp_reg         <= 2'b00;
      pcfg_reg       <= plds_pkg::PCFG_RST;
      dscfg_reg      <= plds_pkg::DSCFG_RST;
      dsev_reg       <= 1'b0;
      top_reg        <= plds_pkg::SPD_1000;
      spd_reg        <= plds_pkg::SPD_1000;
      fail_reg       <= 3'h0;
      shifted_reg    <= 1'b0;
      up_reg         <= 1'b0;
      nlp_tx_cnt_reg <= '0;
      nlp_rx_cnt_reg <= '0;
      lost_cnt_reg   <= '0;
      nlp_seen_reg   <= 3'h0;
      nlp_prev_reg   <= 1'b0;
      nlp_tx_reg     <= 1'b0;
      txen_reg       <= 1'b0;
      rxen_reg       <= 1'b0;
      idle_reg       <= 1'b0;
      pwr_prev_reg   <= 1'b0;
      reinit_reg     <= 1'b0;
      fail_prev_reg  <= 1'b0;
      an_prev_reg    <= 1'b0;
      rdata_reg      <= 16'h0000;
    end
    else
    begin
      ctrl_reg       <= ctrl_next;
      adv_reg        <= adv_next;
      lp_reg         <= lp_next;
      pcfg_reg       <= pcfg_next;
      dscfg_reg      <= dscfg_next;
      dsev_reg       <= dsev_next;
      top_reg        <= top_next;
      spd_reg        <= spd_next;
      fail_reg       <= fail_next;
      shifted_reg    <= shifted_next;
      up_reg         <= up_next;
      nlp_tx_cnt_reg <= nlp_tx_cnt_next;
      nlp_rx_cnt_reg <= nlp_rx_cnt_next;
      lost_cnt_reg   <= lost_cnt_next;
      nlp_seen_reg   <= nlp_seen_next;
      nlp_prev_reg   <= nlp_prev_next;
      nlp_tx_reg     <= nlp_tx_next;
      txen_reg       <= txen_next;
      rxen_reg       <= rxen_next;
      idle_reg       <= idle_next;
      pwr_prev_reg   <= pwr_prev_next;
      reinit_reg     <= reinit_next;
      fail_prev_reg  <= fail_prev_next;
      an_prev_reg    <= an_prev_next;
      rdata_reg      <= rdata_next;
    end
  end

  // Outputs straight from flip-flops
  assign rdata         = rdata_reg;
  assign send_idle     = idle_reg;
  assign nlp_tx        = nlp_tx_reg;
  assign tx_enable     = txen_reg;
  assign rx_enable     = rxen_reg;
  assign analog_reinit = reinit_reg;
  assign adv_top_speed = top_reg;
  assign link_up       = up_reg;

endmodule : plds_link_ctrl

// [testbench/plds_link_ctrl_sva.sv]
/*
  Port checker for the link criteria and speed downshift block.
  Assumes it sees only the top module's ports; it is bound in after the module.
*/
`timescale 1ns/10ps
module plds_link_ctrl_sva #(
  parameter int NLP_TX_CYC  = 100,
  parameter int RESTORE_CYC = 500
) (
  // Clock and reset
  input wire logic                clk,
  input wire logic                arst_n,
  // Register port
  input wire plds_pkg::plds_req_t req,
  input wire logic [15:0]         rdata,
  // Line side and status
  input wire logic                send_idle,
  input wire logic                nlp_tx,
  input wire logic                tx_enable,
  input wire logic                rx_enable,
  input wire logic                analog_reinit,
  input wire logic [1:0]          adv_top_speed,
  input wire logic                mac_pwrdn,
  input wire logic                link_up
);
  logic [31:0] gap_reg;
  logic [31:0] gap_next;
  logic [31:0] down_reg;
  logic [31:0] down_next;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // Cycles since the last pulse and since link was last up; saturate so long waits stay valid
  always_comb
  begin
    gap_next  = (gap_reg != 32'h0 && gap_reg != '1) ? gap_reg + 32'h1 : gap_reg;
    down_next = (down_reg != '1) ? down_reg + 32'h1 : down_reg;
    if (nlp_tx)
      gap_next = 32'h1;
    if (link_up)
      down_next = 32'h0;
  end

  // Helper registers
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      gap_reg  <= 32'h0;
      down_reg <= 32'h0;
    end
    else
    begin
      gap_reg  <= gap_next;
      down_reg <= down_next;
    end
  end

  // A read taken one edge ago, and a power-down request held
  sequence rd_taken;
    $past(req.rd);
  endsequence
  sequence pwr_held;
    mac_pwrdn [*3];
  endsequence

  rd_idle_a: assert property (!$past(req.rd) |-> rdata == 16'h0)
    else $error("read data not zero outside a read answer");
  rd_unmapped_a: assert property (
    rd_taken ##0 !($past(req.addr) inside {5'h00, 5'h04, 5'h05, 5'h10, 5'h11, 5'h13, 5'h1b})
    |-> rdata == 16'h0)
    else $error("unmapped read not zero");
  spd_down_a: assert property (
    rd_taken ##0 ($past(req.addr) == 5'h11 && !$past(link_up) && !link_up) |-> rdata == 16'h0)
    else $error("speed shown while link down");
  spd_code_a: assert property (
    rd_taken ##0 $past(req.addr) == 5'h11 |-> rdata[13:0] == 14'h0 && rdata[15:14] != 2'b11)
    else $error("speed status malformed");
  pwr_quiet_a: assert property (
    pwr_held |-> !tx_enable && !rx_enable && !link_up && !send_idle)
    else $error("activity during power-down");
  reinit_pulse_a: assert property (analog_reinit |=> !analog_reinit)
    else $error("reinit pulse too long");
  adv_step_a: assert property (
    $changed(adv_top_speed) |-> adv_top_speed == 2'b10
    || adv_top_speed == $past(adv_top_speed) - 2'b01)
    else $error("advertised speed skipped a step");
  restore_wait_a: assert property (
    adv_top_speed == 2'b10 && $past(adv_top_speed) != 2'b10 |-> down_reg >= 32'(RESTORE_CYC))
    else $error("advertisement restored too early");
  nlp_gap_a: assert property (
    nlp_tx && gap_reg != 32'h0 |-> gap_reg >= 32'(NLP_TX_CYC))
    else $error("link pulse too soon");
endmodule : plds_link_ctrl_sva

bind plds_link_ctrl plds_link_ctrl_sva #(.NLP_TX_CYC(NLP_TX_CYC), .RESTORE_CYC(RESTORE_CYC))
  u_sva (.clk(clk), .arst_n(arst_n), .req(req), .rdata(rdata), .send_idle(send_idle),
  .nlp_tx(nlp_tx), .tx_enable(tx_enable), .rx_enable(rx_enable),
  .analog_reinit(analog_reinit), .adv_top_speed(adv_top_speed), .mac_pwrdn(mac_pwrdn),
  .link_up(link_up));

// [testbench/plds_partner.sv]
/*
  Behavioural link partner: negotiates, trains or locks, or sends link pulses.
  Assumes the bench commands presence and a bad cable; supports all three speeds.
*/
`timescale 1ns/10ps
module plds_partner #(
  parameter logic [1:0] LP_PAUSE = 2'b10,
  parameter int         NLP_GAP  = 150
) (
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            arst_n,
  // Scenario controls
  input  wire logic            present,
  input  wire logic            cable_bad,
  input  wire logic [1:0]      adv_top_speed,
  // Indications towards the device
  output plds_pkg::plds_line_t line_out,
  output logic [1:0]           lp_pause,
  output logic [1:0]           neg_speed
);
  logic [15:0] step;

  assign lp_pause = LP_PAUSE; // Partner {asym,pause} abilities

  // Negotiate at step 40, train or lock at 60, retry at 70 after a failure
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n || !present)
    begin
      step      <= 16'h0;
      line_out  <= '0;
      neg_speed <= 2'b00;
    end
    else
    begin
      step <= step + 16'h1;
      if (step == 16'd40)
      begin
        neg_speed        <= adv_top_speed;
        line_out.an_done <= 1'b1;
      end
      if (step == 16'd60 && neg_speed != plds_pkg::SPD_10)
      begin
        if (cable_bad)
          line_out.gig_fail <= 1'b1;
        else if (neg_speed == plds_pkg::SPD_1000)
          line_out[7:5] <= 3'b111; // Both trained, valid symbols follow
        else
          line_out[4:3] <= 2'b11; // Descrambler lock and idle rate
      end
      if (step == 16'd70 && line_out.gig_fail)
      begin
        step     <= 16'h0;
        line_out <= '0;
      end
      // Pulses four cycles wide, well inside the accepted spacing
      line_out.normal_link_pulse <= line_out.an_done && neg_speed == plds_pkg::SPD_10
        && (int'(step) % NLP_GAP) < 4;
    end
  end
endmodule : plds_partner

// [testbench/tb_top.sv]
/*
  Self-checking bench for plds_link_ctrl driving the register port and a link partner.
  Assumes shortened timing parameters: pulse 100, pulse timeout 200, restore 500 cycles.
*/
`timescale 1ns/10ps
module tb_top;
  logic                 clk = 1'b0;
  logic                 arst_n = 1'b1;
  plds_pkg::plds_req_t  req;
  plds_pkg::plds_line_t line_w;
  logic [15:0]          rdata;
  logic [1:0]           lp_pause_w, neg_w, adv_top_speed;
  logic                 send_idle, nlp_tx, tx_enable, rx_enable, analog_reinit, link_up;
  logic                 present, cable_bad, mac_pwrdn, gf_q;
  int                   err_total = 0;
  int                   n_compared = 0;
  int                   fails = 0;
  int                   pulses = 0;
  int                   reinits = 0;
  int                   lim, i;

  always #4 clk = ~clk;

  plds_link_ctrl #(.NLP_TX_CYC(100), .NLP_MAX_CYC(200), .RESTORE_CYC(500)) uut (.clk(clk),
    .arst_n(arst_n), .req(req), .rdata(rdata), .line_in(line_w), .lp_pause_in(lp_pause_w),
    .neg_speed_in(neg_w), .send_idle(send_idle), .nlp_tx(nlp_tx), .tx_enable(tx_enable),
    .rx_enable(rx_enable), .analog_reinit(analog_reinit), .adv_top_speed(adv_top_speed),
    .mac_pwrdn(mac_pwrdn), .link_up(link_up));

  plds_partner u_lp (.clk(clk), .arst_n(arst_n), .present(present), .cable_bad(cable_bad),
    .adv_top_speed(adv_top_speed), .line_out(line_w), .lp_pause(lp_pause_w),
    .neg_speed(neg_w));

  // Count failed attempts, sent pulses and re-initialisations as they happen
  always @(posedge clk)
  begin
    gf_q <= line_w.gig_fail;
    fails   = fails + int'(line_w.gig_fail === 1'b1 && gf_q === 1'b0);
    pulses  = pulses + int'(nlp_tx === 1'b1);
    reinits = reinits + int'(analog_reinit === 1'b1);
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= {1'b1, 1'b0, a, d};
    @(posedge clk);
    req <= '0;
  endtask : wr_reg

  // Data stand only in the cycle after the read strobe
  task automatic rd_reg(input logic [4:0] a, input logic [15:0] exp);
    @(posedge clk);
    req <= {1'b0, 1'b1, a, 16'h0};
    @(posedge clk);
    req <= '0;
    @(negedge clk);
    chk(rdata, exp);
  endtask : rd_reg

  task automatic do_reset();
    arst_n    <= 1'b0;
    req       <= '0;
    present   <= 1'b0;
    cable_bad <= 1'b0;
    mac_pwrdn <= 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
  endtask : do_reset

  task automatic wait_link(input logic v);
    for (i = 0; i < 3000 && link_up !== v; i++)
      @(negedge clk);
    chk({15'h0, link_up}, {15'h0, v});
  endtask : wait_link

  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  // Main sequence
  initial
  begin
    do_reset();
    rd_reg(5'h00, 16'h1000);
    rd_reg(5'h10, 16'h0000);
    rd_reg(5'h1b, 16'h0080);
    wr_reg(5'h11, 16'hffff);
    wr_reg(5'h03, 16'hffff);
    rd_reg(5'h11, 16'h0000);
    rd_reg(5'h03, 16'h0000);
    wr_reg(5'h04, 16'h0400);
    rd_reg(5'h04, 16'h0400);
    present <= 1'b1;
    wait_link(1'b1);
    chk({15'h0, send_idle}, 16'h0001);
    rd_reg(5'h11, 16'h8000);
    rd_reg(5'h05, 16'h0800);
    rd_reg(5'h13, 16'h0000);
    wr_reg(5'h00, 16'h1800);
    wait_link(1'b0);
    rd_reg(5'h00, 16'h1800);
    wr_reg(5'h00, 16'h1000);
    wait_link(1'b1);
    rd_reg(5'h04, 16'h0400);
    chk(16'(reinits), 16'h0001);
    @(posedge clk);
    mac_pwrdn <= 1'b1;
    wait_link(1'b0);
    chk({14'h0, tx_enable, rx_enable}, 16'h0000);
    $display("gigabit link and power-down test done");
    // Without downshift the top speed must survive repeated failures
    @(posedge clk);
    do_reset();
    cable_bad <= 1'b1;
    present   <= 1'b1;
    fails = 0;
    for (i = 0; i < 1000 && fails < 3; i++)
      @(negedge clk);
    chk({14'h0, adv_top_speed}, 16'h0002);
    $display("no downshift test done");
    // Failure limits 5 down to 1, counted on the partner's failure indications
    for (lim = 5; lim >= 1; lim--)
    begin
      @(posedge clk);
      do_reset();
      wr_reg(5'h10, 16'h0080);
      wr_reg(5'h1b, 16'(lim << 6));
      fails = 0;
      cable_bad <= 1'b1;
      present   <= 1'b1;
      for (i = 0; i < 3000 && adv_top_speed !== 2'b01; i++)
        @(negedge clk);
      chk(16'(fails), 16'(lim));
      rd_reg(5'h13, 16'h0020);
      rd_reg(5'h13, 16'h0000);
      $display("downshift limit %0d test done", lim);
    end
    // Second step down to 10 Mb/s, link on pulses, then restore after loss
    pulses = 0;
    for (i = 0; i < 3000 && adv_top_speed !== 2'b00; i++)
      @(negedge clk);
    chk({14'h0, adv_top_speed}, 16'h0000);
    wait_link(1'b1);
    chk({15'h0, tx_enable}, 16'h0001);
    rd_reg(5'h11, 16'h0000);
    chk({15'h0, pulses != 0}, 16'h0001);
    @(posedge clk);
    present <= 1'b0;
    repeat (300) @(negedge clk);
    chk({14'h0, adv_top_speed}, 16'h0000);
    repeat (800) @(negedge clk);
    chk({14'h0, adv_top_speed}, 16'h0002);
    $display("restore test done");
    // Restored advertisement fails once more, then a good cable gives a fast link
    present <= 1'b1;
    for (i = 0; i < 3000 && adv_top_speed !== 2'b01; i++)
      @(negedge clk);
    chk({14'h0, adv_top_speed}, 16'h0001);
    cable_bad <= 1'b0;
    wait_link(1'b1);
    chk({15'h0, send_idle}, 16'h0001);
    rd_reg(5'h11, 16'h4000);
    $display("fast link test done");
    report_and_stop();
  end

  // Watchdog well beyond the expected run of about 3000 cycles
  initial
  begin
    #160000;
    err_total++;
    report_and_stop();
  end
endmodule : tb_top
